// ---- logic/ssc_ctrl.sv ----
// register file, commands, write guard, interrupts and bit-clock divider
// How it works
// - loop bit feeds receive data, sync and clock from transmit side.
// - enable-set writes set mask bits, enable-clear writes clear them.
// - interrupt only for events whose mask bit is set.
// - guard_on protects configuration registers against writes.
// - protected: divider, rx/tx clock and frame configs, both compare patterns.
// - blocked write sets violation flag and records offending offset.
// - reading the guard report clears the violation flag.
// - offsets 0x100 to 0x128 are not decoded here.
// - rx_on_cmd enables receiver unless rx_off_cmd in same write.
// - rx_off_cmd disables receiver after current word completes.
// - tx_on_cmd enables transmitter unless tx_off_cmd in same write.
// - tx_off_cmd disables transmitter after current word shifts out.
// - soft_reset_cmd resets controller except write guard state and tx word, and beats all other command bits.
// - divider value zero stops the divided clock.
// - nonzero N gives bit clock at peripheral clock over 2N.
// - divider supports values up to 4095.
`timescale 1ns/1ps
module ssc_ctrl #(
  parameter int DIV_W = ssc_pkg::DIV_W
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [8:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_rx_busy,
  input wire logic i_tx_busy,
  input wire logic [ssc_pkg::EVT_W-1:0] i_evt,
  input wire logic i_tx_data,
  input wire logic i_tx_sync,
  input wire logic i_tx_clk,
  input wire logic i_rx_data_pin,
  input wire logic i_rx_sync_pin,
  input wire logic i_rx_clk_pin,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_rx_on,
  output logic o_tx_on,
  output logic o_soft_rst,
  output logic o_bit_tick,
  output logic o_rx_data,
  output logic o_rx_sync,
  output logic o_rx_clk,
  output logic [31:0] o_tx_word,
  output logic o_tx_word_wr,
  output logic o_rx_word_rd
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic irq;
    logic rx_on;
    logic rx_off_pend;
    logic tx_on;
    logic tx_off_pend;
    logic soft_rst;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    logic [31:0] rx_clk_cfg;
    logic [31:0] rx_frm_cfg;
    logic [31:0] tx_clk_cfg;
    logic [31:0] tx_frm_cfg;
    logic [31:0] tx_sync;
    logic [31:0] cmp_a;
    logic [31:0] cmp_b;
    logic [31:0] tx_word;
    logic tx_word_wr;
    logic rx_word_rd;
    logic [ssc_pkg::EVT_W-1:0] flags;
    logic [ssc_pkg::EVT_W-1:0] mask;
    logic guard_on;
    logic guard_flag;
    logic [8:0] guard_src;
    logic rx_data;
    logic rx_sync;
    logic rx_clk;
  } ssc_state_t;

  ssc_state_t s_q;
  ssc_state_t s_d;

  // decode used by both write guard and write path
  function automatic logic ssc_is_guarded(input logic [8:0] a);
    return a == ssc_pkg::OFF_DIVIDER || a == ssc_pkg::OFF_RX_CLK_CFG ||
           a == ssc_pkg::OFF_RX_FRM_CFG || a == ssc_pkg::OFF_TX_CLK_CFG ||
           a == ssc_pkg::OFF_TX_FRM_CFG || a == ssc_pkg::OFF_CMP_A ||
           a == ssc_pkg::OFF_CMP_B;
  endfunction : ssc_is_guarded

  logic wr_ok;
  logic wr_blocked;
  logic [31:0] rd_mux;
  logic loop_on;
  assign loop_on = s_q.rx_frm_cfg[ssc_pkg::BIT_LOOP];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.tx_word_wr = 1'b0;
    s_d.rx_word_rd = 1'b0;
    s_d.soft_rst = 1'b0;
    wr_blocked = i_wr && s_q.guard_on && ssc_is_guarded(i_addr);
    wr_ok = i_wr && !wr_blocked;
    // read mux; dma window and reserved offsets read zero
    rd_mux = ssc_pkg::RST_ZERO;
    unique case (i_addr)
      ssc_pkg::OFF_DIVIDER: rd_mux = 32'(s_q.div);
      ssc_pkg::OFF_RX_CLK_CFG: rd_mux = s_q.rx_clk_cfg;
      ssc_pkg::OFF_RX_FRM_CFG: rd_mux = s_q.rx_frm_cfg;
      ssc_pkg::OFF_TX_CLK_CFG: rd_mux = s_q.tx_clk_cfg;
      ssc_pkg::OFF_TX_FRM_CFG: rd_mux = s_q.tx_frm_cfg;
      ssc_pkg::OFF_TX_SYNC: rd_mux = s_q.tx_sync;
      ssc_pkg::OFF_CMP_A: rd_mux = s_q.cmp_a;
      ssc_pkg::OFF_CMP_B: rd_mux = s_q.cmp_b;
      ssc_pkg::OFF_EVENT_FLAGS: rd_mux = 32'(s_q.flags);
      ssc_pkg::OFF_IRQ_MASK: rd_mux = 32'(s_q.mask);
      ssc_pkg::OFF_GUARD_CFG: rd_mux = 32'(s_q.guard_on);
      ssc_pkg::OFF_GUARD_RPT:
        rd_mux = {15'h0000, s_q.guard_src, 7'h00, s_q.guard_flag};
      default: rd_mux = ssc_pkg::RST_ZERO;
    endcase
    s_d.rdata = i_rd ? rd_mux : ssc_pkg::RST_ZERO;
    if (i_rd && i_addr == ssc_pkg::OFF_RX_WORD) begin
      s_d.rx_word_rd = 1'b1;
    end
    if (i_rd && i_addr == ssc_pkg::OFF_GUARD_RPT) begin
      s_d.guard_flag = 1'b0;
    end
    // record violation; set wins over read clear
    if (wr_blocked) begin
      s_d.guard_flag = 1'b1;
      s_d.guard_src = i_addr;
    end
    if (wr_ok) begin
      unique case (i_addr)
        ssc_pkg::OFF_DIVIDER: s_d.div = i_wdata[DIV_W-1:0];
        ssc_pkg::OFF_RX_CLK_CFG: s_d.rx_clk_cfg = i_wdata;
        ssc_pkg::OFF_RX_FRM_CFG: s_d.rx_frm_cfg = i_wdata;
        ssc_pkg::OFF_TX_CLK_CFG: s_d.tx_clk_cfg = i_wdata;
        ssc_pkg::OFF_TX_FRM_CFG: s_d.tx_frm_cfg = i_wdata;
        ssc_pkg::OFF_TX_SYNC: s_d.tx_sync = i_wdata;
        ssc_pkg::OFF_CMP_A: s_d.cmp_a = i_wdata;
        ssc_pkg::OFF_CMP_B: s_d.cmp_b = i_wdata;
        ssc_pkg::OFF_TX_WORD: begin
          s_d.tx_word = i_wdata;
          s_d.tx_word_wr = 1'b1;
        end
        ssc_pkg::OFF_IRQ_SET: s_d.mask = s_q.mask | i_wdata[ssc_pkg::EVT_W-1:0];
        ssc_pkg::OFF_IRQ_CLR: s_d.mask = s_q.mask & ~i_wdata[ssc_pkg::EVT_W-1:0];
        ssc_pkg::OFF_GUARD_CFG: s_d.guard_on = i_wdata[ssc_pkg::BIT_GUARD_ON];
        default: ;
      endcase
    end
    if (s_q.rx_off_pend && !i_rx_busy) begin
      s_d.rx_on = 1'b0;
      s_d.rx_off_pend = 1'b0;
    end
    if (s_q.tx_off_pend && !i_tx_busy) begin
      s_d.tx_on = 1'b0;
      s_d.tx_off_pend = 1'b0;
    end
    if (wr_ok && i_addr == ssc_pkg::OFF_COMMAND) begin
      if (i_wdata[ssc_pkg::BIT_RX_OFF]) begin
        s_d.rx_off_pend = i_rx_busy && s_q.rx_on;
        s_d.rx_on = i_rx_busy && s_q.rx_on;
      end else if (i_wdata[ssc_pkg::BIT_RX_ON]) begin
        s_d.rx_on = 1'b1;
        s_d.rx_off_pend = 1'b0;
      end
      if (i_wdata[ssc_pkg::BIT_TX_OFF]) begin
        s_d.tx_off_pend = i_tx_busy && s_q.tx_on;
        s_d.tx_on = i_tx_busy && s_q.tx_on;
      end else if (i_wdata[ssc_pkg::BIT_TX_ON]) begin
        s_d.tx_on = 1'b1;
        s_d.tx_off_pend = 1'b0;
      end
    end
    // interrupt: sticky flags, hardware set; only soft reset below reloads them and beats the set
    s_d.flags = s_q.flags | i_evt;
    // masked interrupt; or-reduce of status anded with mask
    s_d.irq = |(s_d.flags & s_d.mask);
    // divider idle at zero; tick every N cycles gives period 2N
    s_d.tick = 1'b0;
    if (s_q.div == '0) begin
      s_d.div_cnt = '0;
    end else if (s_q.div_cnt >= s_q.div - 1'b1) begin
      s_d.div_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 1'b1;
    end
    s_d.rx_data = loop_on ? i_tx_data : i_rx_data_pin;
    s_d.rx_sync = loop_on ? i_tx_sync : i_rx_sync_pin;
    s_d.rx_clk = loop_on ? i_tx_clk : i_rx_clk_pin;
    // soft reset beats every other command bit
    if (wr_ok && i_addr == ssc_pkg::OFF_COMMAND && i_wdata[ssc_pkg::BIT_SOFT_RST]) begin
      s_d.soft_rst = 1'b1;
      s_d.rx_on = 1'b0;
      s_d.tx_on = 1'b0;
      s_d.rx_off_pend = 1'b0;
      s_d.tx_off_pend = 1'b0;
      s_d.div = '0;
      s_d.div_cnt = '0;
      s_d.tick = 1'b0;
      s_d.rx_clk_cfg = ssc_pkg::RST_ZERO;
      s_d.rx_frm_cfg = ssc_pkg::RST_ZERO;
      s_d.tx_clk_cfg = ssc_pkg::RST_ZERO;
      s_d.tx_frm_cfg = ssc_pkg::RST_ZERO;
      s_d.tx_sync = ssc_pkg::RST_ZERO;
      s_d.cmp_a = ssc_pkg::RST_ZERO;
      s_d.cmp_b = ssc_pkg::RST_ZERO;
      s_d.flags = ssc_pkg::RST_EVENT_FLAGS;
      s_d.mask = '0;
      s_d.irq = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
      s_q.flags <= ssc_pkg::RST_EVENT_FLAGS;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_irq = s_q.irq;
  assign o_rx_on = s_q.rx_on;
  assign o_tx_on = s_q.tx_on;
  assign o_soft_rst = s_q.soft_rst;
  assign o_bit_tick = s_q.tick;
  assign o_rx_data = s_q.rx_data;
  assign o_rx_sync = s_q.rx_sync;
  assign o_rx_clk = s_q.rx_clk;
  assign o_tx_word = s_q.tx_word;
  assign o_tx_word_wr = s_q.tx_word_wr;
  assign o_rx_word_rd = s_q.rx_word_rd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_loop_route;
    @(posedge i_mclk) disable iff (!i_arst_n)
      loop_on |=> o_rx_data == $past(i_tx_data) && o_rx_clk == $past(i_tx_clk) &&
        o_rx_sync == $past(i_tx_sync);
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback route wrong");

  property p_mask_set;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_wr && i_addr == ssc_pkg::OFF_IRQ_SET && i_wdata[0] |=> s_q.mask[0] || $past(o_soft_rst);
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set");

  property p_irq_masked;
    @(posedge i_mclk) disable iff (!i_arst_n)
      o_irq == |(s_q.flags & s_q.mask);
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq without masked event");

  property p_guard_keep;
    @(posedge i_mclk) disable iff (!i_arst_n)
      s_q.guard_on && i_wr && i_addr == ssc_pkg::OFF_CMP_A |=> $stable(s_q.cmp_a);
  endproperty
  a_guard_keep: assert property (p_guard_keep) else $error("protected write took");

  property p_guard_flag;
    @(posedge i_mclk) disable iff (!i_arst_n)
      wr_blocked |=> s_q.guard_flag && s_q.guard_src == $past(i_addr);
  endproperty
  a_guard_flag: assert property (p_guard_flag) else $error("violation not recorded");

  property p_guard_rdclr;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_rd && i_addr == ssc_pkg::OFF_GUARD_RPT && !i_wr |=> !s_q.guard_flag;
  endproperty
  a_guard_rdclr: assert property (p_guard_rdclr) else $error("flag not cleared on read");

  property p_rx_on;
    @(posedge i_mclk) disable iff (!i_arst_n)
      wr_ok && i_addr == ssc_pkg::OFF_COMMAND && i_wdata[0] && !i_wdata[1] && !i_wdata[15]
      |=> o_rx_on;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receiver not enabled");

  property p_soft_rst;
    @(posedge i_mclk) disable iff (!i_arst_n)
      wr_ok && i_addr == ssc_pkg::OFF_COMMAND && i_wdata[15] |=> !o_rx_on && !o_tx_on;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset lost");

  property p_div_idle;
    @(posedge i_mclk) disable iff (!i_arst_n)
      s_q.div == '0 |=> !o_bit_tick;
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("tick with divider off");

  property p_div_rate;
    @(posedge i_mclk) disable iff (!i_arst_n)
      o_bit_tick && s_q.div == 12'h001 && $stable(s_q.div) |=> o_bit_tick || $changed(s_q.div);
  endproperty
  a_div_rate: assert property (p_div_rate) else $error("divide by two wrong");

  property p_tx_on;
    @(posedge i_mclk) disable iff (!i_arst_n)
      wr_ok && i_addr == ssc_pkg::OFF_COMMAND && i_wdata[ssc_pkg::BIT_TX_ON] &&
      !i_wdata[ssc_pkg::BIT_TX_OFF] && !i_wdata[ssc_pkg::BIT_SOFT_RST] |=> o_tx_on;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("transmitter not enabled");

  // a disable written beside an enable must win
  property p_rx_both;
    @(posedge i_mclk) disable iff (!i_arst_n)
      wr_ok && i_addr == ssc_pkg::OFF_COMMAND && i_wdata[ssc_pkg::BIT_RX_ON] &&
      i_wdata[ssc_pkg::BIT_RX_OFF] && !o_rx_on |=> !o_rx_on;
  endproperty
  a_rx_both: assert property (p_rx_both) else $error("enable beat disable");

  property p_rx_defer;
    @(posedge i_mclk) disable iff (!i_arst_n)
      o_rx_on && i_rx_busy && wr_ok && i_addr == ssc_pkg::OFF_COMMAND &&
      i_wdata[ssc_pkg::BIT_RX_OFF] && !i_wdata[ssc_pkg::BIT_SOFT_RST] |=> o_rx_on;
  endproperty
  a_rx_defer: assert property (p_rx_defer) else $error("receiver cut mid word");

  property p_rx_release;
    @(posedge i_mclk) disable iff (!i_arst_n)
      s_q.rx_off_pend && !i_rx_busy &&
      !(wr_ok && i_addr == ssc_pkg::OFF_COMMAND) |=> !o_rx_on;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("receiver kept on");

  property p_tx_defer;
    @(posedge i_mclk) disable iff (!i_arst_n)
      o_tx_on && i_tx_busy && wr_ok && i_addr == ssc_pkg::OFF_COMMAND &&
      i_wdata[ssc_pkg::BIT_TX_OFF] && !i_wdata[ssc_pkg::BIT_SOFT_RST] |=> o_tx_on;
  endproperty
  a_tx_defer: assert property (p_tx_defer) else $error("transmitter cut mid word");

  property p_tx_release;
    @(posedge i_mclk) disable iff (!i_arst_n)
      s_q.tx_off_pend && !i_tx_busy &&
      !(wr_ok && i_addr == ssc_pkg::OFF_COMMAND) |=> !o_tx_on;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("transmitter kept on");

  property p_div_upper;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_rd && i_addr == ssc_pkg::OFF_DIVIDER |=> o_rdata[31:DIV_W] == '0;
  endproperty
  a_div_upper: assert property (p_div_upper) else $error("divider upper bits set");

  // the dma channel owns this window, so nothing here may answer it
  property p_dma_gap;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_rd && i_addr >= ssc_pkg::OFF_DMA_LO &&
      i_addr <= ssc_pkg::OFF_DMA_HI |=> o_rdata == '0;
  endproperty
  a_dma_gap: assert property (p_dma_gap) else $error("dma window decoded");
endmodule : ssc_ctrl

// ---- logic/ssc_pkg.sv ----
// constants for the synchronous serial control plane
package ssc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFF_COMMAND = 9'h000;
  localparam logic [8:0] OFF_DIVIDER = 9'h004;
  localparam logic [8:0] OFF_RX_CLK_CFG = 9'h010;
  localparam logic [8:0] OFF_RX_FRM_CFG = 9'h014;
  localparam logic [8:0] OFF_TX_CLK_CFG = 9'h018;
  localparam logic [8:0] OFF_TX_FRM_CFG = 9'h01c;
  localparam logic [8:0] OFF_RX_WORD = 9'h020;
  localparam logic [8:0] OFF_TX_WORD = 9'h024;
  localparam logic [8:0] OFF_RX_SYNC = 9'h030;
  localparam logic [8:0] OFF_TX_SYNC = 9'h034;
  localparam logic [8:0] OFF_CMP_A = 9'h038;
  localparam logic [8:0] OFF_CMP_B = 9'h03c;
  localparam logic [8:0] OFF_EVENT_FLAGS = 9'h040;
  localparam logic [8:0] OFF_IRQ_SET = 9'h044;
  localparam logic [8:0] OFF_IRQ_CLR = 9'h048;
  localparam logic [8:0] OFF_IRQ_MASK = 9'h04c;
  localparam logic [8:0] OFF_GUARD_CFG = 9'h0e4;
  localparam logic [8:0] OFF_GUARD_RPT = 9'h0e8;
  localparam logic [8:0] OFF_DMA_LO = 9'h100;
  localparam logic [8:0] OFF_DMA_HI = 9'h128;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_RX_ON = 0;
  localparam int BIT_RX_OFF = 1;
  localparam int BIT_TX_ON = 8;
  localparam int BIT_TX_OFF = 9;
  localparam int BIT_SOFT_RST = 15;
  localparam int BIT_LOOP = 5;
  localparam int BIT_GUARD_ON = 0;
  localparam int BIT_GUARD_FLAG = 0;
  localparam int POS_GUARD_SRC = 8;
  localparam int DIV_W = 12;
  localparam int EVT_W = 8;
  localparam int BIT_EVT_RX_RDY = 0;
  localparam int BIT_EVT_TX_RDY = 2;
  localparam int BIT_EVT_TX_EMPTY = 3;
  localparam int BIT_EVT_RX_OVR = 4;
  localparam int BIT_EVT_TX_DONE = 6;
  localparam int BIT_EVT_RX_DONE = 7;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0] RST_EVENT_FLAGS = 8'hcc;
endpackage : ssc_pkg

// ---- testbench/ssc_peer_model.sv ----
// far-side serial peer: word timing and receive pin levels
`timescale 1ns/1ps
module ssc_peer_model #(
  parameter int LEN = 16
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_start,
  output logic o_busy,
  output logic o_data,
  output logic o_sync,
  output logic o_clk
);
  int cnt;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 0;
      o_data <= 1'b0;
      o_clk <= 1'b0;
    end else begin
      if (i_start) begin
        cnt <= LEN;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      // clock stands still between words; data never holds a stale level
      o_clk <= (cnt > 0) ? ~o_clk : 1'b0;
      o_data <= ~o_data;
    end
  end
  assign o_busy = (cnt > 0);
  assign o_sync = (cnt == LEN);
endmodule : ssc_peer_model

// ---- testbench/sync_serial_control_plane_tb_top.sv ----
// self-checking bench for the serial control plane
`timescale 1ns/1ps
module sync_serial_control_plane_tb_top;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [8:0] i_addr = 9'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [ssc_pkg::EVT_W-1:0] i_evt = '0;
  logic i_tx_data = 1'b0;
  logic i_tx_sync = 1'b0;
  logic i_tx_clk = 1'b0;
  logic start = 1'b0;
  logic busy, pdat, psync, pclk;
  logic [31:0] o_rdata, o_tx_word;
  logic o_irq, o_rx_on, o_tx_on, o_soft_rst, o_bit_tick;
  logic o_rx_data, o_rx_sync, o_rx_clk, o_tx_word_wr, o_rx_word_rd;
  logic [8:0] prot [7] = '{9'h004, 9'h010, 9'h014, 9'h018, 9'h01c, 9'h038, 9'h03c};
  int num_errors = 0;
  int checks = 0;
  int g;
  always #4 i_mclk = ~i_mclk;
  ssc_ctrl u_dut (.i_mclk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_rx_busy(busy), .i_tx_busy(busy), .i_evt, .i_tx_data, .i_tx_sync, .i_tx_clk,
    .i_rx_data_pin(pdat), .i_rx_sync_pin(psync), .i_rx_clk_pin(pclk), .o_rdata, .o_irq,
    .o_rx_on, .o_tx_on, .o_soft_rst, .o_bit_tick, .o_rx_data, .o_rx_sync, .o_rx_clk,
    .o_tx_word, .o_tx_word_wr, .o_rx_word_rd);
  ssc_peer_model u_peer (.i_mclk, .i_arst_n, .i_start(start), .o_busy(busy),
    .o_data(pdat), .o_sync(psync), .o_clk(pclk));
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    cmp(o_rdata & m, e);
  endtask : rd
  // cycles between two ticks, zero when no tick comes
  task automatic tick_gap(output int n);
    int k;
    int t0;
    n = 0;
    t0 = -1;
    for (k = 0; k < 9000 && n == 0; k++) begin
      cyc(1);
      if (o_bit_tick === 1'b1) begin
        if (t0 >= 0) begin
          n = k - t0;
        end
        t0 = k;
      end
    end
  endtask : tick_gap
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (60000) @(posedge i_mclk);
    num_errors++;
    stop_test();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    foreach (prot[i]) rd(prot[i], 32'h0000_0000);
    rd(9'h040, 32'h0000_00cc);
    rd(9'h04c, 32'h0000_0000);
    rd(9'h0e8, 32'h0000_0000);
    cmp(32'(o_irq), 32'h0000_0000);
    rd(9'h008, 32'h0000_0000);
    wr(9'h100, 32'hffff_ffff);
    rd(9'h100, 32'h0000_0000);
    rd(9'h128, 32'h0000_0000);
    wr(9'h004, 32'hffff_ffff);
    rd(9'h004, 32'h0000_0fff);
    tick_gap(g);
    cmp(32'(g), 32'h0000_0fff);
    wr(9'h004, 32'h0000_0003);
    tick_gap(g);
    cmp(32'(g), 32'h0000_0003);
    wr(9'h004, 32'h0000_0001);
    tick_gap(g);
    cmp(32'(g), 32'h0000_0001);
    wr(9'h004, 32'h0000_0000);
    tick_gap(g);
    cmp(32'(g), 32'h0000_0000);
    i_tx_data <= 1'b1;
    i_tx_sync <= 1'b1;
    i_tx_clk <= 1'b1;
    wr(9'h014, 32'h0000_0020);
    cyc(2);
    cmp(32'({o_rx_data, o_rx_sync, o_rx_clk}), 32'h0000_0007);
    i_tx_clk <= 1'b0;
    cyc(2);
    cmp(32'({o_rx_data, o_rx_sync, o_rx_clk}), 32'h0000_0006);
    wr(9'h014, 32'h0000_0000);
    cyc(2);
    cmp(32'({o_rx_sync, o_rx_clk}), 32'h0000_0000);
    wr(9'h044, 32'h0000_0004);
    rd(9'h04c, 32'h0000_0004);
    cmp(32'(o_irq), 32'h0000_0001);
    wr(9'h048, 32'h0000_0004);
    rd(9'h04c, 32'h0000_0000);
    cmp(32'(o_irq), 32'h0000_0000);
    wr(9'h044, 32'h0000_0001);
    cyc(2);
    cmp(32'(o_irq), 32'h0000_0000);
    i_evt <= 8'h01;
    @(posedge i_mclk);
    i_evt <= 8'h00;
    rd(9'h040, 32'h0000_00cd);
    cmp(32'(o_irq), 32'h0000_0001);
    wr(9'h048, 32'h0000_0001);
    cyc(2);
    cmp(32'(o_irq), 32'h0000_0000);
    wr(9'h0e4, 32'h0000_0001);
    rd(9'h0e4, 32'h0000_0001);
    foreach (prot[i]) begin
      wr(prot[i], 32'h0000_0a5a);
      rd(prot[i], 32'h0000_0000);
      rd(9'h0e8, {15'h0000, prot[i], 8'h01});
      rd(9'h0e8, 32'h0000_0000, 32'h0000_0001);
    end
    wr(9'h034, 32'h0000_0a5a);
    rd(9'h034, 32'h0000_0a5a);
    rd(9'h0e8, 32'h0000_0000, 32'h0000_0001);
    wr(9'h0e4, 32'h0000_0000);
    wr(9'h004, 32'h0000_0005);
    rd(9'h004, 32'h0000_0005);
    wr(9'h024, 32'h1234_5678);
    cmp(o_tx_word, 32'h1234_5678);
    cmp(32'(o_tx_word_wr), 32'h0000_0001);
    rd(9'h020, 32'h0000_0000);
    cmp(32'(o_rx_word_rd), 32'h0000_0001);
    wr(9'h000, 32'h0000_0003);
    cyc(2);
    cmp(32'(o_rx_on), 32'h0000_0000);
    wr(9'h000, 32'h0000_0101);
    cyc(2);
    cmp(32'({o_rx_on, o_tx_on}), 32'h0000_0003);
    @(posedge i_mclk);
    start <= 1'b1;
    @(posedge i_mclk);
    start <= 1'b0;
    wr(9'h000, 32'h0000_0202);
    cyc(2);
    cmp(32'({o_rx_on, o_tx_on}), 32'h0000_0003);
    for (g = 0; g < 50 && busy === 1'b1; g++) cyc(1);
    cyc(2);
    cmp(32'({o_rx_on, o_tx_on}), 32'h0000_0000);
    wr(9'h000, 32'h0000_0300);
    cyc(2);
    cmp(32'(o_tx_on), 32'h0000_0000);
    wr(9'h044, 32'h0000_0004);
    wr(9'h000, 32'h0000_8101);
    cmp(32'(o_soft_rst), 32'h0000_0001);
    cyc(2);
    cmp(32'({o_rx_on, o_tx_on, o_irq}), 32'h0000_0000);
    rd(9'h004, 32'h0000_0000);
    rd(9'h04c, 32'h0000_0000);
    stop_test();
  end
endmodule : sync_serial_control_plane_tb_top
